//--- adc_cfg_regs.sv
// serial write-only configuration bank of an eight-channel converter
//
// Function
// - transfer is 16 clocks, top three bits address
// - write bit zero discards the whole transfer
// - write 1, select 00 loads control
// - write 1, select 01 loads first range
// - write 1, select 10 loads second range
// - write 1, select 11 loads sequence register
// - all registers write-only, no readback
// - control register resets to zero
// - new control applies to following conversion
// - address picks channel or consecutive end
// - mode bits select input arrangement
// - pair modes route 2k positive, 2k+1 negative
// - power code 11 is full shutdown
// - code 10 shuts down at 15th rise
// - code 01 standby at 15th rise
// - code 00 keeps everything powered
// - bit 5 chooses output coding
// - bit 4 chooses internal or external reference
// - bits 3,2 hold sequencer control
// - bit 1 chooses weak drive or float
// - sequencer none, flagged list, or consecutive
// - range codes, plus/minus 10 V default
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic conv_done,
  output logic [11:0] ctrl_out,
  output logic [7:0] range_lo_out,
  output logic [7:0] range_hi_out,
  output logic [7:0] seq_out,
  output logic [2:0] chan_next,
  output logic [1:0] range_next,
  output logic [3:0] pos_sel,
  output logic [3:0] neg_sel,
  output logic straight_binary,
  output logic int_ref_sel,
  output logic circuit_on,
  output logic reference_on,
  output logic dout_weak,
  output logic dout_idle_bit,
  output logic xfer_done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11
  } xfer_state_t;

  logic sclk_s, cs_n_s, din_s;
  logic sclk_d_ff, cs_d_ff;
  logic fall_ev, rise_ev, frame_start, frame_end;
  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_sclk (
    .ref_clk(ref_clk), .rst(rst), .pin(sclk), .level(sclk_s));
  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
    .ref_clk(ref_clk), .rst(rst), .pin(cs_n), .level(cs_n_s));
  pin_sync3 #(.RESET_VAL(1'b0)) u_sync_din (
    .ref_clk(ref_clk), .rst(rst), .pin(din), .level(din_s));
  assign fall_ev = sclk_d_ff & ~sclk_s & ~cs_n_s;
  assign rise_ev = ~sclk_d_ff & sclk_s & ~cs_n_s;
  assign frame_start = cs_d_ff & ~cs_n_s;
  assign frame_end = ~cs_d_ff & cs_n_s;
  // transfer and register state
  xfer_state_t state_ff, nxt_state;
  logic [15:0] sh_ff, nxt_sh;
  logic [4:0] cnt_ff, nxt_cnt, rcnt_ff, nxt_rcnt;
  logic wr_ff, nxt_wr, upd_ff, nxt_upd, asleep_ff, nxt_asleep;
  logic [1:0] sel_ff, nxt_sel;
  logic [11:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rlo_ff, nxt_rlo, rhi_ff, nxt_rhi, seq_ff, nxt_seq;
  logic done_ff, nxt_done, cir_ff, nxt_cir, refon_ff, nxt_refon;
  logic commit_ctrl, commit_byte;
  logic [1:0] pm;
  assign pm = ctrl_ff[adc_cfg_pkg::CF_PM_HI:adc_cfg_pkg::CF_PM_LO];

  always_comb begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_rcnt = rcnt_ff;
    nxt_wr = wr_ff;
    nxt_sel = sel_ff;
    nxt_upd = upd_ff;
    nxt_asleep = asleep_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rlo = rlo_ff;
    nxt_rhi = rhi_ff;
    nxt_seq = seq_ff;
    nxt_done = 1'b0;
    commit_ctrl = 1'b0;
    commit_byte = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (frame_start) begin
          nxt_state = ST_SHIFT;
          nxt_cnt = 5'h00;
          nxt_rcnt = 5'h00;
          nxt_wr = 1'b0;
          nxt_upd = 1'b0;
          nxt_asleep = 1'b0; // wake at frame start
        end
      end
      ST_SHIFT: begin
        if (frame_end) begin
          nxt_state = ST_IDLE;
        end else if (fall_ev) begin
          nxt_sh = {sh_ff[14:0], din_s};
          nxt_cnt = cnt_ff + 5'h01;
          if (nxt_cnt == adc_cfg_pkg::CNT_HDR) begin
            nxt_wr = nxt_sh[2];
            nxt_sel = nxt_sh[1:0];
          end
          // write bit 0 leaves wr_ff low and nothing commits
          if (wr_ff && nxt_cnt == adc_cfg_pkg::CNT_CTRL_DONE &&
              sel_ff == adc_cfg_pkg::SEL_CTRL) begin
            commit_ctrl = 1'b1;
            nxt_ctrl = nxt_sh[11:0];
            nxt_upd = 1'b1;
          end
          if (wr_ff && nxt_cnt == adc_cfg_pkg::CNT_BYTE_DONE &&
              sel_ff != adc_cfg_pkg::SEL_CTRL) begin
            commit_byte = 1'b1;
            case (sel_ff)
              adc_cfg_pkg::SEL_RANGE_LO: nxt_rlo = nxt_sh[7:0];
              adc_cfg_pkg::SEL_RANGE_HI: nxt_rhi = nxt_sh[7:0];
              default: nxt_seq = nxt_sh[7:0];
            endcase
          end
          if (nxt_cnt == adc_cfg_pkg::CNT_XFER) begin
            nxt_state = ST_DONE; // later bits ignored
            nxt_done = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (frame_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (state_ff != ST_IDLE && rise_ev && !frame_end) begin
      nxt_rcnt = (rcnt_ff == 5'h1f) ? rcnt_ff : rcnt_ff + 5'h01;
      if (nxt_rcnt == adc_cfg_pkg::CNT_PD && upd_ff &&
          (pm == adc_cfg_pkg::PM_AUTOSHUT || pm == adc_cfg_pkg::PM_STANDBY)) begin
        nxt_asleep = 1'b1;
      end
    end
    // sleep is only ever set under an auto code; code 00 keeps all on
    nxt_cir = !(pm == adc_cfg_pkg::PM_FULLSHUT || asleep_ff);
    nxt_refon = !(pm == adc_cfg_pkg::PM_FULLSHUT ||
                  (asleep_ff && pm == adc_cfg_pkg::PM_AUTOSHUT));
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      sh_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      rcnt_ff <= 5'h00;
      wr_ff <= 1'b0;
      sel_ff <= 2'h0;
      upd_ff <= 1'b0;
      asleep_ff <= 1'b0;
      ctrl_ff <= adc_cfg_pkg::CTRL_RESET;
      rlo_ff <= adc_cfg_pkg::RANGE_RESET;
      rhi_ff <= adc_cfg_pkg::RANGE_RESET;
      seq_ff <= adc_cfg_pkg::SEQ_RESET;
      done_ff <= 1'b0;
      cir_ff <= 1'b1;
      refon_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_n_s;
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      rcnt_ff <= nxt_rcnt;
      wr_ff <= nxt_wr;
      sel_ff <= nxt_sel;
      upd_ff <= nxt_upd;
      asleep_ff <= nxt_asleep;
      ctrl_ff <= nxt_ctrl;
      rlo_ff <= nxt_rlo;
      rhi_ff <= nxt_rhi;
      seq_ff <= nxt_seq;
      done_ff <= nxt_done;
      cir_ff <= nxt_cir;
      refon_ff <= nxt_refon;
    end
  end

  // sequencer: channel for the following conversion
  logic [2:0] chan_ff, nxt_chan, addr;
  logic [1:0] rng_ff, nxt_rng, sq;
  assign sq = {ctrl_ff[adc_cfg_pkg::CF_SEQ_A], ctrl_ff[adc_cfg_pkg::CF_SEQ_B]};
  assign addr = ctrl_ff[adc_cfg_pkg::CF_ADDR_HI:adc_cfg_pkg::CF_ADDR_LO];

  // next flagged channel above cur, wrapping; sequence msb is channel 0
  function automatic logic [2:0] next_flagged(input logic [2:0] cur,
                                              input logic [7:0] flags,
                                              input logic [2:0] dflt);
    logic [2:0] res;
    logic [2:0] idx;
    res = dflt;
    // farthest first, so the nearest flagged channel wins
    for (int i = 8; i >= 1; i--) begin
      idx = cur + 3'(i);
      if (flags[3'h7 - idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction : next_flagged

  always_comb begin
    nxt_chan = chan_ff;
    case (sq)
      adc_cfg_pkg::SQ_LIST: begin
        if (upd_ff && done_ff) begin
          nxt_chan = next_flagged(3'h7, seq_ff, addr);
        end else if (conv_done) begin
          nxt_chan = next_flagged(chan_ff, seq_ff, addr);
        end
      end
      adc_cfg_pkg::SQ_CONSEC: begin
        if (upd_ff && done_ff) begin
          nxt_chan = 3'h0;
        end else if (conv_done) begin
          nxt_chan = (chan_ff >= addr) ? 3'h0 : chan_ff + 3'h1;
        end
      end
      default: nxt_chan = addr;
    endcase
    case (nxt_chan[1:0])
      2'h0: nxt_rng = nxt_chan[2] ? rhi_ff[7:6] : rlo_ff[7:6];
      2'h1: nxt_rng = nxt_chan[2] ? rhi_ff[5:4] : rlo_ff[5:4];
      2'h2: nxt_rng = nxt_chan[2] ? rhi_ff[3:2] : rlo_ff[3:2];
      default: nxt_rng = nxt_chan[2] ? rhi_ff[1:0] : rlo_ff[1:0];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chan_ff <= 3'h0;
      rng_ff <= 2'h0;
    end else begin
      chan_ff <= nxt_chan;
      rng_ff <= nxt_rng;
    end
  end

  // input routing for the following conversion
  cfg_route_if rt ();
  input_router u_router (.rt(rt));
  assign rt.chan = chan_ff;
  assign rt.mode = ctrl_ff[adc_cfg_pkg::CF_MODE_HI:adc_cfg_pkg::CF_MODE_LO];
  logic [3:0] pos_ff, neg_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_ff <= 4'h0;
      neg_ff <= adc_cfg_pkg::SRC_GND;
    end else begin
      pos_ff <= rt.pos_sel;
      neg_ff <= rt.neg_sel;
    end
  end

  // configuration goes only to the converter core, never to a read port
  assign ctrl_out = ctrl_ff;
  assign range_lo_out = rlo_ff;
  assign range_hi_out = rhi_ff;
  assign seq_out = seq_ff;
  assign chan_next = chan_ff;
  assign range_next = rng_ff;
  assign pos_sel = pos_ff;
  assign neg_sel = neg_ff;
  assign straight_binary = ctrl_ff[adc_cfg_pkg::CF_CODING];
  assign int_ref_sel = ctrl_ff[adc_cfg_pkg::CF_REF];
  assign circuit_on = cir_ff;
  assign reference_on = refon_ff;
  assign dout_weak = ctrl_ff[adc_cfg_pkg::CF_WEAK];
  assign dout_idle_bit = chan_ff[2];
  assign xfer_done = done_ff;

  chk_ctrl_reset: assert property (@(posedge ref_clk) $past(rst) |-> ctrl_ff == 12'h000)
    else $error("control not zero after reset");
  chk_discard_write: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ST_SHIFT && cnt_ff >= 5'h03 && !wr_ff) |=>
    ($stable(ctrl_ff) && $stable(rlo_ff) && $stable(rhi_ff) && $stable(seq_ff)))
    else $error("register changed in a discarded transfer");
  chk_ctrl_load: assert property (@(posedge ref_clk) disable iff (rst)
    commit_ctrl |=> (ctrl_ff == $past(nxt_sh[11:0]) && cnt_ff == 5'h0f && sel_ff == 2'h0))
    else $error("control load wrong");
  chk_range_lo: assert property (@(posedge ref_clk) disable iff (rst)
    (commit_byte && sel_ff == 2'h1) |=> (rlo_ff == $past(nxt_sh[7:0]) && cnt_ff == 5'h0b))
    else $error("first range load wrong");
  chk_range_hi: assert property (@(posedge ref_clk) disable iff (rst)
    (commit_byte && sel_ff == 2'h2) |=> (rhi_ff == $past(nxt_sh[7:0]) && $stable(rlo_ff)))
    else $error("second range load wrong");
  chk_seq_load: assert property (@(posedge ref_clk) disable iff (rst)
    (commit_byte && sel_ff == 2'h3) |=> (seq_ff == $past(nxt_sh[7:0]) && $stable(ctrl_ff)))
    else $error("sequence load wrong");
  chk_xfer_len: assert property (@(posedge ref_clk) disable iff (rst)
    done_ff |-> (cnt_ff == 5'h10 && state_ff == ST_DONE))
    else $error("transfer end not at sixteen bits");
  chk_auto_shut: assert property (@(posedge ref_clk) disable iff (rst)
    (rise_ev && !frame_end && state_ff != ST_IDLE && rcnt_ff == 5'h0e && upd_ff &&
     pm == 2'h2) |=> ##1 (!circuit_on && !reference_on))
    else $error("autoshutdown not entered on fifteenth rise");
  chk_auto_standby: assert property (@(posedge ref_clk) disable iff (rst)
    (rise_ev && !frame_end && state_ff != ST_IDLE && rcnt_ff == 5'h0e && upd_ff &&
     pm == 2'h1) |=> ##1 (!circuit_on && reference_on))
    else $error("autostandby not entered on fifteenth rise");
  chk_full_shut: assert property (@(posedge ref_clk) disable iff (rst)
    (pm == 2'h3 && $past(pm) == 2'h3) |-> (!circuit_on && !reference_on))
    else $error("full shutdown left circuitry on");
  chk_normal_on: assert property (@(posedge ref_clk) disable iff (rst)
    (pm == 2'h0 && $past(pm) == 2'h0) |-> (circuit_on && reference_on))
    else $error("normal mode powered down");
  chk_consec_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (conv_done && sq == 2'h2 && !(upd_ff && done_ff) && chan_ff == addr) |=> chan_ff == 3'h0)
    else $error("consecutive sequence did not wrap");
endmodule : adc_cfg_regs
`default_nettype wire

//--- adc_cfg_pkg.sv
// shared constants for the serial configuration register bank
package adc_cfg_pkg;
  localparam int XFER_BITS = 16;
  localparam int HDR_BITS = 3;
  localparam int CTRL_BITS = 12;
  localparam int RANGE_BITS = 8;
  localparam int SEQ_BITS = 8;
  localparam int PD_EDGE = 15;
  // bit counts at which a payload is complete, and the rising-edge count for power-down
  localparam logic [4:0] CNT_HDR = 5'h03;
  localparam logic [4:0] CNT_CTRL_DONE = 5'h0f;
  localparam logic [4:0] CNT_BYTE_DONE = 5'h0b;
  localparam logic [4:0] CNT_XFER = 5'h10;
  localparam logic [4:0] CNT_PD = 5'h0f;
  // register select codes
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_RANGE_LO = 2'h1;
  localparam logic [1:0] SEL_RANGE_HI = 2'h2;
  localparam logic [1:0] SEL_SEQ = 2'h3;
  // control field positions (12-bit register)
  localparam int CF_ADDR_HI = 11;
  localparam int CF_ADDR_LO = 9;
  localparam int CF_MODE_HI = 8;
  localparam int CF_MODE_LO = 7;
  localparam int CF_PM_HI = 6;
  localparam int CF_PM_LO = 5;
  localparam int CF_CODING = 4;
  localparam int CF_REF = 3;
  localparam int CF_SEQ_A = 2;
  localparam int CF_SEQ_B = 1;
  localparam int CF_WEAK = 0;
  // reset values
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [7:0] RANGE_RESET = 8'h00;
  localparam logic [7:0] SEQ_RESET = 8'h00;
  // input arrangement codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_PSEUDO4 = 2'h1;
  localparam logic [1:0] MODE_DIFF4 = 2'h2;
  localparam logic [1:0] MODE_PSEUDO7 = 2'h3;
  // power codes
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_AUTOSHUT = 2'h2;
  localparam logic [1:0] PM_FULLSHUT = 2'h3;
  // sequencer codes {a,b}
  localparam logic [1:0] SQ_LIST = 2'h1;
  localparam logic [1:0] SQ_CONSEC = 2'h2;
  // input source codes: 0..7 pins, then ground and temperature
  localparam logic [3:0] SRC_GND = 4'h8;
  localparam logic [3:0] SRC_TEMP = 4'h9;
  localparam logic [3:0] SRC_COMMON = 4'h7;
endpackage : adc_cfg_pkg

//--- cfg_route_if.sv
// channel routing signals between the bank and its input router
`timescale 1ns/1ps
`default_nettype none
interface cfg_route_if;
  logic [2:0] chan;
  logic [1:0] mode;
  logic [3:0] pos_sel;
  logic [3:0] neg_sel;
  modport bank (output chan, output mode, input pos_sel, input neg_sel);
  modport router (input chan, input mode, output pos_sel, output neg_sel);
endinterface : cfg_route_if
`default_nettype wire

//--- pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  // change accepted only once stages two and three agree
  always_comb begin
    nxt_lvl = (s2_ff == s3_ff) ? s2_ff : lvl_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      lvl_ff <= RESET_VAL;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
endmodule : pin_sync3
`default_nettype wire

//--- input_router.sv
// maps channel address and arrangement onto positive and negative inputs
`timescale 1ns/1ps
`default_nettype none
module input_router (
  cfg_route_if.router rt
);
  always_comb begin
    rt.pos_sel = {1'b0, rt.chan};
    rt.neg_sel = adc_cfg_pkg::SRC_GND;
    case (rt.mode)
      adc_cfg_pkg::MODE_PSEUDO7: begin
        if (rt.chan == 3'h7) begin
          rt.pos_sel = adc_cfg_pkg::SRC_TEMP;
          rt.neg_sel = adc_cfg_pkg::SRC_TEMP;
        end else begin
          rt.neg_sel = adc_cfg_pkg::SRC_COMMON;
        end
      end
      adc_cfg_pkg::MODE_DIFF4, adc_cfg_pkg::MODE_PSEUDO4: begin
        rt.pos_sel = {1'b0, rt.chan[2:1], 1'b0};
        rt.neg_sel = {1'b0, rt.chan[2:1], 1'b1};
      end
      default: begin
        rt.pos_sel = {1'b0, rt.chan};
        rt.neg_sel = adc_cfg_pkg::SRC_GND;
      end
    endcase
  end
endmodule : input_router
`default_nettype wire

//--- serial_host.sv
// host serial port model framing writes into the configuration bank
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // fewer than 16 bits lifts frame select early
  task automatic frame(input logic [15:0] w, input int nbits);
    // called at a falling edge: keeps every pin change off the rising edges
    #($urandom_range(1, 24));
    cs_n = 1'b0;
    #(200);
    for (int i = 15; i > 15 - nbits; i--) begin
      din = w[i];
      #(100);
      sclk = 1'b0;
      #(200);
      sclk = 1'b1;
      #(100);
    end
    cs_n = 1'b1;
    // released data line must not look like the last bit
    din = ~din;
    #(400);
  endtask : frame
endmodule : serial_host
`default_nettype wire

//--- adc_cfg_regs_bench.sv
// self-checking bench for the serial configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_regs_bench;
  logic ref_clk, rst, conv_done;
  wire sclk, cs_n, din;
  logic [11:0] ctrl_out;
  logic [7:0] range_lo_out, range_hi_out, seq_out;
  logic [2:0] chan_next;
  logic [1:0] range_next;
  logic [3:0] pos_sel, neg_sel;
  logic straight_binary, int_ref_sel, circuit_on, reference_on, dout_weak, dout_idle_bit;
  logic xfer_done;
  int error_cnt = 0;
  int n_tests = 0;
  int xd_cnt = 0;
  int xd_exp = 0;
  logic [11:0] ctrl;
  logic [7:0] rlo, rhi, seq;
  logic [2:0] chan;
  logic pc, pr;

  adc_cfg_regs dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .conv_done(conv_done),
    .ctrl_out(ctrl_out),
    .range_lo_out(range_lo_out),
    .range_hi_out(range_hi_out),
    .seq_out(seq_out),
    .chan_next(chan_next),
    .range_next(range_next),
    .pos_sel(pos_sel),
    .neg_sel(neg_sel),
    .straight_binary(straight_binary),
    .int_ref_sel(int_ref_sel),
    .circuit_on(circuit_on),
    .reference_on(reference_on),
    .dout_weak(dout_weak),
    .dout_idle_bit(dout_idle_bit),
    .xfer_done(xfer_done)
  );
  serial_host host (.sclk(sclk), .cs_n(cs_n), .din(din));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (xfer_done === 1'b1) xd_cnt <= xd_cnt + 1;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(3000000);
    error_cnt++;
    stop_test();
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [2:0] next_flagged(input logic [2:0] from);
    logic [2:0] c;
    for (int k = 1; k <= 8; k++) begin
      c = from + 3'(k);
      if (seq[3'h7 - c]) return c;
    end
    return from;
  endfunction : next_flagged

  function automatic logic [1:0] exp_range(input logic [2:0] ch);
    logic [7:0] r;
    r = ch[2] ? rhi : rlo;
    return 2'(r >> (3'h6 - {ch[1:0], 1'b0}));
  endfunction : exp_range

  function automatic logic [15:0] mk_ctrl(input logic [2:0] a, input logic [1:0] m,
                                          input logic [1:0] p, input logic [1:0] s);
    logic [15:0] r;
    r = 16'($urandom);
    return {3'h4, a, m, p, r[4:3], s, r[1:0]};
  endfunction : mk_ctrl

  task automatic check_all();
    logic [3:0] ep, en;
    ep = {1'b0, chan};
    en = 4'h8;
    if (ctrl[8:7] == 2'h3) begin
      en = 4'h7;
      if (chan == 3'h7) ep = 4'h9;
      if (chan == 3'h7) en = 4'h9;
    end else if (ctrl[8:7] != 2'h0) begin
      ep = {1'b0, chan[2:1], 1'b0};
      en = {1'b0, chan[2:1], 1'b1};
    end
    check("ctrl", 16'(ctrl_out), 16'(ctrl));
    check("range_lo", 16'(range_lo_out), 16'(rlo));
    check("range_hi", 16'(range_hi_out), 16'(rhi));
    check("seq", 16'(seq_out), 16'(seq));
    check("chan", 16'(chan_next), 16'(chan));
    check("range_next", 16'(range_next), 16'(exp_range(chan)));
    check("pos", 16'(pos_sel), 16'(ep));
    check("neg", 16'(neg_sel), 16'(en));
    check("coding", 16'(straight_binary), 16'(ctrl[4]));
    check("ref", 16'(int_ref_sel), 16'(ctrl[3]));
    check("weak", 16'(dout_weak), 16'(ctrl[0]));
    check("idle_bit", 16'(dout_idle_bit), 16'(chan[2]));
    check("circuit", 16'(circuit_on), 16'(pc));
    check("reference", 16'(reference_on), 16'(pr));
    check("xfer_cnt", 16'(xd_cnt), 16'(xd_exp));
  endtask : check_all

  task automatic send(input logic [15:0] w, input int nbits);
    logic ld;
    host.frame(w, nbits);
    ld = w[15] && w[14:13] == 2'h0 && nbits >= 15;
    if (nbits == 16) xd_exp++;
    if (ld) ctrl = w[12:1];
    if (w[15] && nbits >= 11) begin
      if (w[14:13] == 2'h1) rlo = w[12:5];
      if (w[14:13] == 2'h2) rhi = w[12:5];
      if (w[14:13] == 2'h3) seq = w[12:5];
    end
    pc = !(ctrl[6:5] == 2'h3 || (ld && ctrl[6:5] != 2'h0));
    pr = !(ctrl[6:5] == 2'h3 || (ld && ctrl[6:5] == 2'h2));
    if (ld) chan = ctrl[2:1] == 2'h2 ? 3'h0 : ctrl[2:1] == 2'h1 ? next_flagged(3'h7) : ctrl[11:9];
    repeat (4) @(negedge ref_clk);
    check_all();
  endtask : send

  task automatic pulse();
    @(negedge ref_clk);
    conv_done = 1'b1;
    @(negedge ref_clk);
    conv_done = 1'b0;
    if (ctrl[2:1] == 2'h2) chan = (chan == ctrl[11:9]) ? 3'h0 : chan + 3'h1;
    else if (ctrl[2:1] == 2'h1) chan = next_flagged(chan);
    repeat (3) @(negedge ref_clk);
    check_all();
  endtask : pulse

  initial begin
    logic [15:0] w;
    rst = 1'b1;
    conv_done = 1'b0;
    ctrl = 12'h000;
    rlo = 8'h00;
    rhi = 8'h00;
    seq = 8'h00;
    chan = 3'h0;
    pc = 1'b1;
    pr = 1'b1;
    void'($urandom(32'h1543fb48));
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check_all();
    for (int s = 3; s >= 0; s--) begin
      w = 16'($urandom);
      w[15:13] = {1'b1, 2'(s)};
      w[3] = w[2];
      send(w, 16);
    end
    for (int i = 0; i < 4; i++) send(16'($urandom) & 16'h7fff, 16);
    send(mk_ctrl(3'h5, 2'h1, 2'h0, 2'h0), 14);
    send({3'h5, 13'($urandom)}, 10);
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 8; a++) send(mk_ctrl(3'(a), 2'(m), 2'h0, 2'h0), 16);
    end
    for (int p = 3; p >= 0; p--) begin
      send(mk_ctrl(3'h2, 2'h0, 2'(p), 2'h0), 16);
      send(16'h0123, 16);
    end
    // sequence flags set before the sequencer is started
    send({3'h7, 8'($urandom) | 8'h21, 5'h00}, 16);
    send(mk_ctrl(3'h4, 2'h0, 2'h0, 2'h1), 16);
    repeat (10) pulse();
    send(mk_ctrl(3'h3, 2'h2, 2'h0, 2'h2), 16);
    repeat (9) pulse();
    send(mk_ctrl(3'h0, 2'h0, 2'h0, 2'h2), 16);
    repeat (3) pulse();
    send(mk_ctrl(3'h6, 2'h0, 2'h0, 2'h0), 16);
    pulse();
    for (int i = 0; i < 30; i++) begin
      w = 16'($urandom);
      w[3] = w[2];
      send(w, 16);
      if (w[0]) pulse();
    end
    stop_test();
  end
endmodule : adc_cfg_regs_bench
`default_nettype wire
